// [rtl/dpm_host.sv]
// Host controller for one port of an asynchronous dual-port RAM: memory and token latch reads and writes.
// Assumes the RAM pins are wired directly; the bench resolves the data bus from the enable.
`timescale 1ns/1ps
module dpm_host #(
    parameter int ADDR_W = dpm_pkg::DPM_ADDR_W,
    parameter int DATA_W = dpm_pkg::DPM_DATA_W
) (
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              clk_en,
    // User command side
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic              req_write,
    input  wire logic              req_token,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    input  wire logic              req_upper,
    input  wire logic              req_lower,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_rdata,
    output logic                   rsp_contended,
    // RAM port pins
    output logic [ADDR_W-1:0]      ram_addr,
    output logic                   ram_chip_enable_b,
    output logic                   ram_token_latch_select_b,
    output logic                   ram_output_enable_b,
    output logic                   ram_read_write_b,
    output logic                   ram_upper_byte_lane_select_b,
    output logic                   ram_lower_byte_lane_select_b,
    output logic [DATA_W-1:0]      ram_data_out,
    output logic                   ram_data_oe,
    input  wire logic [DATA_W-1:0] ram_data_in,
    input  wire logic              ram_contention_b,
    input  wire logic              ram_mailbox_irq_b,
    output logic                   mailbox_irq
);
    // Only the two depths and two widths of the part have matching pin maps
    if (ADDR_W != 15 && ADDR_W != 16) begin : g_bad_addr_w // R02
        $error("ADDR_W must be 15 or 16");
    end
    if (DATA_W != 16 && DATA_W != 18) begin : g_bad_data_w // R02
        $error("DATA_W must be 16 or 18");
    end
    // The shared counter must hold the longest timing count
    if (dpm_pkg::DPM_ACCESS_CYC >= (1 << dpm_pkg::DPM_CNT_W)) begin : g_bad_cnt_w
        $error("DPM_CNT_W too narrow for the access count");
    end

    // Transfer walk, one state per cycle unless a count stretches it:
    //   IDLE     accept one request, latch address, data, lanes and kind
    //   SETUP    address and lanes settle with every select still high
    //   STROBE   select low; writes hold the strobe, reads wait the access time
    //   RECOVER  selects high again while write data is still driven as hold
    //   DONE     answer pulse is registered for the following cycle
    // A write answers six cycles after it is taken, a read seven.
    // Contention is only reported; retrying is left to the user, because a
    // slave part cannot tell this host whether its master has settled.
    // The mailbox words are plain addresses here: the top word belongs to
    // the far port and the one below it to this port, so the user decides
    // what a write or read there means.
    // The clock enable freezes every flop, so a stalled transfer simply
    // stretches; the RAM is asynchronous and tolerates longer strobes.

    localparam logic [dpm_pkg::DPM_CNT_W-1:0] ACC_CYC = dpm_pkg::DPM_CNT_W'(dpm_pkg::DPM_ACCESS_CYC);
    localparam logic [dpm_pkg::DPM_CNT_W-1:0] SU_CYC  = dpm_pkg::DPM_CNT_W'(dpm_pkg::DPM_SETUP_CYC);
    localparam logic [dpm_pkg::DPM_CNT_W-1:0] REC_CYC = dpm_pkg::DPM_CNT_W'(dpm_pkg::DPM_RECOVER_CYC);

    dpm_pkg::dpm_state_type          state_q, state_d;
    logic [dpm_pkg::DPM_CNT_W-1:0]   cnt_q, cnt_d;
    logic                            wr_q, wr_d;
    logic                            tok_q, tok_d;
    logic                            up_q, up_d;
    logic                            lo_q, lo_d;
    logic [ADDR_W-1:0]               addr_q, addr_d;
    logic [DATA_W-1:0]               wdata_q, wdata_d, rdata_q, rdata_d;
    logic                            cont_q, cont_d;
    logic                            valid_q, valid_d;

    // True in every state that holds the lanes for a transfer
    function automatic logic in_transfer(input dpm_pkg::dpm_state_type s);
        in_transfer = (s != dpm_pkg::DPM_IDLE);
    endfunction

    // True in the states that drive write data around the strobe
    function automatic logic drives_bus(input dpm_pkg::dpm_state_type s);
        drives_bus = (s == dpm_pkg::DPM_SETUP) || (s == dpm_pkg::DPM_STROBE) ||
                     (s == dpm_pkg::DPM_RECOVER);
    endfunction

    // Last cycle of a strobe or recovery wait
    function automatic logic count_done(input logic [dpm_pkg::DPM_CNT_W-1:0] c);
        count_done = (c <= {{(dpm_pkg::DPM_CNT_W-1){1'b0}}, 1'b1});
    endfunction

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        wr_d    = wr_q;
        tok_d   = tok_q;
        up_d    = up_q;
        lo_d    = lo_q;
        addr_d  = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        cont_d  = cont_q;
        valid_d = 1'b0;
        case (state_q)
            dpm_pkg::DPM_IDLE: begin
                if (req_valid) begin
                    wr_d    = req_write;
                    // Low address bits pick one of the eight token latches
                    tok_d   = req_token; // R11
                    addr_d  = req_addr;
                    // Token writes carry only bit 0; zero requests, one releases
                    wdata_d = req_token ? {DATA_W{req_wdata[0]}} : req_wdata; // R19
                    up_d    = req_upper | req_token; // R03
                    lo_d    = req_lower | req_token; // R03
                    cont_d  = 1'b0;
                    cnt_d   = SU_CYC;
                    state_d = dpm_pkg::DPM_SETUP;
                end
            end
            dpm_pkg::DPM_SETUP: begin
                // Address and data settle before any select goes active
                state_d = dpm_pkg::DPM_STROBE;
                cnt_d   = wr_q ? SU_CYC : ACC_CYC;
            end
            dpm_pkg::DPM_STROBE: begin
                // A slave's contention input settles within this window too
                // Under contention the part itself blocks mailbox set and clear
                if (!ram_contention_b) cont_d = 1'b1; // R08 R09 R10 R18
                if (!count_done(cnt_q)) begin
                    cnt_d = cnt_q - 1'b1;
                end else begin
                    // Read data sampled after the full access delay
                    if (!wr_q) rdata_d = ram_data_in; // R04 R12 R20
                    cnt_d   = REC_CYC;
                    state_d = dpm_pkg::DPM_RECOVER;
                end
            end
            dpm_pkg::DPM_RECOVER: begin
                // Selects high for a gap so a token read after write sees the new value
                if (!count_done(cnt_q)) begin
                    cnt_d = cnt_q - 1'b1;
                end else begin
                    state_d = dpm_pkg::DPM_DONE; // R07
                end
            end
            dpm_pkg::DPM_DONE: begin
                valid_d = 1'b1;
                state_d = dpm_pkg::DPM_IDLE;
            end
            default: state_d = dpm_pkg::DPM_IDLE;
        endcase
    end

    // Reset returns every pin to its idle level without waiting for a clock
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= dpm_pkg::DPM_IDLE;
            cnt_q   <= '0;
            wr_q    <= 1'b0;
            tok_q   <= 1'b0;
            up_q    <= 1'b0;
            lo_q    <= 1'b0;
            addr_q  <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
            cont_q  <= 1'b0;
            valid_q <= 1'b0;
        end else if (clk_en) begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            wr_q    <= wr_d;
            tok_q   <= tok_d;
            up_q    <= up_d;
            lo_q    <= lo_d;
            addr_q  <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            cont_q  <= cont_d;
            valid_q <= valid_d;
        end
    end

    logic strobe;
    assign strobe = (state_q == dpm_pkg::DPM_STROBE);

    assign req_ready     = (state_q == dpm_pkg::DPM_IDLE);
    assign rsp_valid     = valid_q;
    assign rsp_rdata     = rdata_q;
    assign rsp_contended = cont_q;

    // Address stays registered through the whole walk
    assign ram_addr                     = addr_q; // R01 R13 R14
    // Chip enable off outside strobes lets the port power down
    assign ram_chip_enable_b            = ~(strobe & ~tok_q); // R16 R04
    assign ram_token_latch_select_b     = ~(strobe & tok_q); // R05
    assign ram_output_enable_b          = ~(strobe & ~wr_q); // R04 R05 R21
    // Strobe rises at the end of STROBE, data held one more state
    assign ram_read_write_b             = ~(strobe & wr_q); // R06
    // Lanes open before the select and close after it
    assign ram_upper_byte_lane_select_b = ~(in_transfer(state_q) & up_q); // R03
    assign ram_lower_byte_lane_select_b = ~(in_transfer(state_q) & lo_q); // R03
    assign ram_data_out                 = wdata_q;
    // Drive only during write, covering set-up and hold around the strobe
    assign ram_data_oe                  = wr_q & drives_bus(state_q); // R06 R21
    // Flag passes straight through; the part clears it on an uncontended read of this port's own mailbox
    assign mailbox_irq                  = ~ram_mailbox_irq_b; // R15 R17
endmodule

// [shared/dpm_pkg.sv]
// Constants for the host-side controller of an asynchronous dual-port RAM with mailbox and token latches.
// Assumes one port of the RAM is wired to this controller's pins and the other port to another host.
// How it works
// R01: Each RAM port is independent; this host drives one port alone.
// R02: Array depth 32K or 64K words, 16 or 18 bits; address 15 or 16 bits.
// R03: Upper and lower lane selects gate each half of the data bus.
// R04: Memory read asserts chip enable and output enable; data waits access delay.
// R05: Token latch access uses latch select instead of chip enable, plus output enable.
// R06: Write ends on rising strobe; data held stable for set-up before it.
// R07: Opposite port write is seen only after flowthrough delay.
// R08: Device drives contention flag to a port touching a busy location.
// R09: Role pin makes contention flags outputs (master) or inputs (slave).
// R10: Several devices combine side by side, one master, rest slaves.
// R11: Eight token latches exist apart from the memory array.
// R12: Each token latch is owned by at most one port at a time.
// R13: Highest word address is the right port's mailbox.
// R14: Second-highest word address is the left port's mailbox.
// R15: Writing the other port's mailbox raises that owner's interrupt flag.
// R16: A port powers down whenever its chip enable is inactive.
// R17: Owner reading its own mailbox clears its flag; other reads leave it.
// R18: Under contention a port cannot set remote interrupt nor clear its own.
// R19: Token writes use bit 0; write zero requests, read zero owns, one releases.
// R20: Token read drives latch value on all data lines, held steady.
// R21: Port data pins float unless a selected read with output enable runs; the RAM model drives the inverse of its last read instead.
package dpm_pkg;
    localparam int DPM_ADDR_W      = 15;
    localparam int DPM_DATA_W      = 18;
    localparam int DPM_TOKEN_W     = 3;
    localparam int DPM_ACCESS_NS   = 25;
    localparam int DPM_SETUP_NS    = 15;
    localparam int DPM_RECOVER_NS  = 10;
    localparam int DPM_CLK_NS      = 10;
    // Least times round up to whole cycles
    localparam int DPM_ACCESS_CYC  = (DPM_ACCESS_NS + DPM_CLK_NS - 1) / DPM_CLK_NS;
    localparam int DPM_SETUP_CYC   = (DPM_SETUP_NS + DPM_CLK_NS - 1) / DPM_CLK_NS;
    localparam int DPM_RECOVER_CYC = (DPM_RECOVER_NS + DPM_CLK_NS - 1) / DPM_CLK_NS;
    localparam int DPM_CNT_W       = 4;

    typedef enum logic [2:0] {
        DPM_IDLE    = 3'b000,
        DPM_SETUP   = 3'b001,
        DPM_STROBE  = 3'b010,
        DPM_RECOVER = 3'b011,
        DPM_DONE    = 3'b100
    } dpm_state_type;
endpackage

// [verification/dpm_host_assertions.sv]
// Port assertions for dpm_host.
// Bound into each instance; sees its ports only.
`timescale 1ns/1ps
module dpm_host_checker (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic req_write,
    input wire logic rsp_valid,
    input wire logic ram_chip_enable_b,
    input wire logic ram_token_latch_select_b,
    input wire logic ram_output_enable_b,
    input wire logic ram_read_write_b,
    input wire logic ram_data_oe
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b || !clk_en);
    wire any_sel = !(ram_chip_enable_b && ram_token_latch_select_b);
    sequence take_rd; req_valid && req_ready && !req_write; endsequence
    sequence take_wr; req_valid && req_ready && req_write; endsequence
    sequence rd_strobe; (any_sel && !ram_output_enable_b)[*3]; endsequence
    sequence wr_strobe; (any_sel && !ram_read_write_b)[*2]; endsequence
    one_sel_a: assert property (ram_chip_enable_b || ram_token_latch_select_b)
        else $error("both selects low");
    rd_drive_a: assert property (!ram_output_enable_b |-> ram_read_write_b && !ram_data_oe)
        else $error("bus driven in read");
    wr_drive_a: assert property (!ram_read_write_b |-> ram_data_oe && any_sel)
        else $error("bad write strobe");
    idle_quiet_a: assert property (req_ready |-> !any_sel && !ram_data_oe)
        else $error("active while idle");
    rd_walk_a: assert property (take_rd |-> ##2 rd_strobe ##1 !any_sel ##2 rsp_valid)
        else $error("bad read walk");
    wr_walk_a: assert property (take_wr |-> ##2 wr_strobe ##1 ram_read_write_b && ram_data_oe)
        else $error("bad write walk");
    wr_done_a: assert property (take_wr |-> ##6 rsp_valid)
        else $error("write answer late");
    rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid && req_ready)
        else $error("bad answer pulse");
    freeze_hold_a: assert property (disable iff (!rst_b) !clk_en |=>
        $stable({ram_chip_enable_b, ram_output_enable_b, ram_read_write_b, ram_data_oe, rsp_valid}))
        else $error("moved while frozen");
endmodule
bind dpm_host dpm_host_checker u_chk (.*);

// [verification/dpm_ram_model.sv]
// One RAM port with mailbox and token latches.
// The far port is reduced to the clash and mail inputs.
`timescale 1ns/1ps
module dpm_ram_model (
    input  wire logic [14:0] addr,
    input  wire logic        ce_b,
    input  wire logic        sem_b,
    input  wire logic        oe_b,
    input  wire logic        rw_b,
    input  wire logic        ub_b,
    input  wire logic        lb_b,
    input  wire logic [17:0] din,
    input  wire logic        clash,
    input  wire logic        mail,
    output logic      [17:0] dq,
    output logic             busy_b,
    output logic             int_b
);
    logic [17:0] mem [0:32767];
    logic [7:0]  tok = 8'hFF;
    logic [17:0] last = 18'h0;
    logic        sem_w = 1'b0;
    wire         wr = !rw_b && !(ce_b && sem_b);
    wire         rd = rw_b && !oe_b && !(ce_b && sem_b);
    assign busy_b = !clash;
    // Released bus shows the inverse so a stale value cannot pass
    assign dq = rd ? last : ~last;
    initial int_b = 1'h1;
    always @(posedge mail) int_b = 1'h0;
    // Target caught at strobe start; selects rise together at its end
    always @(posedge wr) sem_w = !sem_b;
    always @(negedge wr) begin
        if (sem_w) tok[addr[2:0]] = din[0];
        else begin
            if (!ub_b) mem[addr][17:9] = din[17:9];
            if (!lb_b) mem[addr][8:0] = din[8:0];
        end
    end
    always @(posedge rd) begin
        last = sem_b ? mem[addr] : {18{tok[addr[2:0]]}};
        if (sem_b && addr == 15'h7FFE && !clash) int_b = 1'h1;
    end
endmodule

// [verification/tb.sv]
// Self-checking bench for dpm_host on a behavioural RAM port.
// Inputs change on the falling edge; answers are scored from a queue.
`timescale 1ns/1ps
module tb;
    logic        mclk = 0, rst_b = 0, clk_en = 1, req_valid = 0, req_write = 0, req_token = 0;
    logic        req_upper = 0, req_lower = 0, clash = 0, mail = 0, req_ready, rsp_valid, rsp_contended;
    logic        ram_chip_enable_b, ram_token_latch_select_b, ram_output_enable_b, ram_read_write_b;
    logic        ram_upper_byte_lane_select_b, ram_lower_byte_lane_select_b, ram_data_oe, mailbox_irq;
    logic        ram_contention_b, ram_mailbox_irq_b;
    logic        frz = 0;
    logic [14:0] req_addr = 0, ram_addr, a;
    logic [15:0] lf = 16'h0060;
    logic [17:0] req_wdata = 0, rsp_rdata, ram_data_out, ram_data_in, dq, d, last_rd = 0;
    logic [18:0] q[$];
    int          err_count = 0, n_compared = 0;
    dpm_host uut (.*);
    dpm_ram_model ram (.addr(ram_addr), .ce_b(ram_chip_enable_b), .sem_b(ram_token_latch_select_b),
        .oe_b(ram_output_enable_b), .rw_b(ram_read_write_b), .ub_b(ram_upper_byte_lane_select_b),
        .lb_b(ram_lower_byte_lane_select_b), .din(ram_data_out), .clash(clash), .mail(mail), .dq(dq),
        .busy_b(ram_contention_b), .int_b(ram_mailbox_irq_b));
    assign ram_data_in = ram_data_oe ? ram_data_out : dq;
    always #5 mclk = ~mclk;
    task automatic chk(input logic [18:0] got, input logic [18:0] want);
        n_compared++;
        if (got !== want) begin
            err_count++;
            $display("ERROR %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic tally_and_finish;
        $display("Compared %0d, errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // m is {write, token}; n is {upper, lower}; e is the read data due
    task automatic op(input logic [1:0] m, input logic [14:0] ad, input logic [17:0] wd,
                      input logic [1:0] n, input logic [17:0] e);
        @(negedge mclk);
        {req_valid, req_write, req_token, req_addr, req_wdata, req_upper, req_lower} = {1'h1, m, ad, wd, n};
        if (!m[1]) last_rd = e;
        q.push_back({clash, last_rd});
        @(negedge mclk) req_valid = 1'h0;
        if (frz) begin
            clk_en = 1'h0;
            repeat (3) @(negedge mclk);
            clk_en = 1'h1;
        end
        for (int k = 0; k < 12 && rsp_valid !== 1'h1; k++) @(negedge mclk);
    endtask
    always @(posedge mclk) if (rsp_valid === 1'h1) chk({rsp_contended, rsp_rdata}, q.pop_front());
    initial begin
        #50000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(negedge mclk);
        rst_b = 1'h1;
        for (int i = 0; i < 12; i++) begin
            lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
            a = {1'h0, lf[13:0]};
            d = {lf[1:0], lf};
            clash = 1'h0;
            op(2'h2, a, d, 2'h3, 18'h0);
            op(2'h2, a, ~d, {i % 3 != 1, i % 3 != 0}, 18'h0);
            clash = lf[2];
            op(2'h0, a, 18'h0, 2'h3, {i % 3 != 1 ? ~d[17:9] : d[17:9], i % 3 != 0 ? ~d[8:0] : d[8:0]});
        end
        clash = 1'h0;
        for (int k = 0; k < 8; k++) begin
            op(2'h3, 15'(k), 18'h0, 2'h0, 18'h0);
            op(2'h1, 15'(k), 18'h0, 2'h0, 18'h0);
            op(2'h3, 15'(k), 18'h1, 2'h0, 18'h0);
            op(2'h1, 15'(k), 18'h0, 2'h0, 18'h3FFFF);
        end
        op(2'h2, 15'h7FFE, 18'h0A5A5, 2'h3, 18'h0);
        op(2'h2, 15'h7FFF, 18'h15A5A, 2'h3, 18'h0);
        @(negedge mclk) mail = 1'h1;
        @(negedge mclk) mail = 1'h0;
        chk({18'h0, mailbox_irq}, 19'h1);
        frz = 1'h1;
        op(2'h0, 15'h7FFF, 18'h0, 2'h3, 18'h15A5A);
        frz = 1'h0;
        chk({18'h0, mailbox_irq}, 19'h1);
        clash = 1'h1;
        op(2'h0, 15'h7FFE, 18'h0, 2'h3, 18'h0A5A5);
        chk({18'h0, mailbox_irq}, 19'h1);
        clash = 1'h0;
        op(2'h0, 15'h7FFE, 18'h0, 2'h3, 18'h0A5A5);
        chk({18'h0, mailbox_irq}, 19'h0);
        @(negedge mclk);
        chk(19'(q.size()), 19'h0);
        tally_and_finish();
    end
endmodule
